// file: hdl/pic_ctrl.sv
// Three-level vectored interrupt controller with register port and event status
`timescale 1ns/1ns
`default_nettype none
module pic_ctrl
  import pic_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Byte register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // Single-bit register port
  input  wire logic [7:0]        bit_addr,
  input  wire logic              bit_wdata,
  input  wire logic              bit_wr,
  input  wire logic              bit_rd,
  output logic                   bit_rdata,
  // Peripheral requests, indexed by vector
  input  wire logic [NSRC-1:0]   irq_src,
  // Core side
  input  wire logic              core_shutdown_state,
  input  wire logic              irq_ack,
  input  wire logic              irq_ret,
  output logic                   irq_req,
  output logic      [3:0]        irq_vector,
  output logic      [1:0]        irq_level,
  // Wake-up path
  input  wire logic [WAKE_W-1:0] wake_src,
  output logic                   core_wake,
  // System interrupt from event status
  output logic                   sys_irq
);

  logic [7:0]      irq_enable_main_r;
  logic [7:0]      irq_enable_priority_second_r;
  logic [7:0]      irq_level_main_r;
  logic [7:0]      irq_pin_config_r;
  logic [NSRC-1:0] stat_r;
  logic [NSRC-1:0] stat_nxt;
  logic [NSRC-1:0] mask_r;
  logic [NSRC-1:0] pend_r;
  logic [NSRC-1:0] pend_nxt;
  logic [2:0]      active_r;
  logic [2:0]      active_nxt;
  logic            req_r;
  logic            req_nxt;
  logic [3:0]      vec_r;
  logic [1:0]      lvl_r;
  logic [7:0]      rdata_r;
  logic [7:0]      rdata_nxt;
  logic            brdata_r;
  logic            brdata_nxt;
  logic            wake_r;

  logic            global_irq_enable;
  logic [NSRC-1:0] en_vec;
  logic [NSRC-1:0] pin_ok;
  logic [1:0]      lvl_of [NSRC];
  logic [NSRC-1:0] set_vec;
  logic [NSRC-1:0] cand;
  logic [NSRC-1:0] cand_lv [4];
  logic [1:0]      best_lvl;
  logic [3:0]      poll_vec;
  logic [1:0]      cur_top;
  logic [NSRC-1:0] clr_vec;
  logic [NSRC-1:0] ack_vec;

  // Write strobes per register
  logic wr_ie, wr_irq_enable_priority_second, wr_ip, wr_irq_pin_config;
  logic bw_ie, bw_ip;
  assign wr_ie    = reg_wr && (reg_addr == OFS_IE);
  assign wr_irq_enable_priority_second = reg_wr && (reg_addr == OFS_IRQ_ENABLE_PRIORITY_SECOND);
  assign wr_ip    = reg_wr && (reg_addr == OFS_IP);
  assign wr_irq_pin_config = reg_wr && (reg_addr == OFS_IRQ_PIN_CONFIG);
  assign bw_ie    = bit_wr && pic_bit_hit(bit_addr, BIT_IE_BASE);
  assign bw_ip    = bit_wr && pic_bit_hit(bit_addr, BIT_IP_BASE);

  // Main enable register; byte write wins over a bit write in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_enable_main_r <= RST_IE;
    end else if (wr_ie) begin
      irq_enable_main_r <= reg_wdata;
    end else if (bw_ie) begin
      irq_enable_main_r[bit_addr[2:0]] <= bit_wdata;
    end
  end

  // Main level register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_level_main_r <= RST_IP;
    end else if (wr_ip) begin
      irq_level_main_r <= reg_wdata;
    end else if (bw_ip) begin
      irq_level_main_r[bit_addr[2:0]] <= bit_wdata;
    end
  end

  // Byte-only registers; bit accesses never reach them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_enable_priority_second_r <= RST_IRQ_ENABLE_PRIORITY_SECOND;
      irq_pin_config_r             <= RST_IRQ_PIN_CONFIG;
    end else begin
      if (wr_irq_enable_priority_second) irq_enable_priority_second_r <= reg_wdata;
      if (wr_irq_pin_config) irq_pin_config_r <= reg_wdata & IRQ_PIN_CONFIG_RD_MASK;
    end
  end

  assign global_irq_enable = irq_enable_main_r[IE_GLOBAL];

  // Per-source enable and level; the top level is fixed, not writable
  always_comb begin
    en_vec             = '0;
    en_vec[VEC_EXT0]   = irq_enable_main_r[B_EXT0];
    en_vec[VEC_T0]     = irq_enable_main_r[B_T0];
    en_vec[VEC_EXT1]   = irq_enable_main_r[B_EXT1];
    en_vec[VEC_T1]     = irq_enable_main_r[B_T1];
    en_vec[VEC_UART]   = irq_enable_main_r[B_UART];
    en_vec[VEC_T2]     = irq_enable_main_r[B_T2];
    en_vec[VEC_TEMP]   = irq_enable_main_r[B_TEMP];
    en_vec[VEC_ENERGY] = irq_enable_priority_second_r[E2_ENERGY_EN];
    en_vec[VEC_RTC]    = irq_enable_priority_second_r[E2_RTC_EN];
    en_vec[VEC_PSM]    = irq_enable_priority_second_r[E2_PSM_EN];
    en_vec[VEC_SBUS]   = irq_enable_priority_second_r[E2_SBUS_EN];
    en_vec[VEC_AUX]    = 1'b1; // Spare source, gated by the global enable only
    for (int i = 0; i < NSRC; i++) begin
      lvl_of[i] = LVL_LOW;
    end
    lvl_of[VEC_PSM]    = LVL_TOP;
    lvl_of[VEC_EXT0]   = irq_level_main_r[B_EXT0] ? LVL_HIGH : LVL_LOW;
    lvl_of[VEC_T0]     = irq_level_main_r[B_T0] ? LVL_HIGH : LVL_LOW;
    lvl_of[VEC_EXT1]   = irq_level_main_r[B_EXT1] ? LVL_HIGH : LVL_LOW;
    lvl_of[VEC_T1]     = irq_level_main_r[B_T1] ? LVL_HIGH : LVL_LOW;
    lvl_of[VEC_UART]   = irq_level_main_r[B_UART] ? LVL_HIGH : LVL_LOW;
    lvl_of[VEC_T2]     = irq_level_main_r[B_T2] ? LVL_HIGH : LVL_LOW;
    lvl_of[VEC_TEMP]   = irq_level_main_r[B_TEMP] ? LVL_HIGH : LVL_LOW;
    lvl_of[VEC_ENERGY] = irq_level_main_r[B_ENERGY_PRI] ? LVL_HIGH : LVL_LOW;
    lvl_of[VEC_RTC]    = irq_enable_priority_second_r[E2_RTC_PRI] ? LVL_HIGH : LVL_LOW;
    lvl_of[VEC_SBUS]   = irq_enable_priority_second_r[E2_SBUS_PRI] ? LVL_HIGH : LVL_LOW;
  end

  // External inputs pass only when their pin function enables them
  always_comb begin
    pin_ok           = '1;
    pin_ok[VEC_EXT0] = irq_pin_config_r[PIN_EXT0_EN];
    pin_ok[VEC_EXT1] = irq_pin_config_r[PIN_EXT1_HI] && irq_pin_config_r[PIN_EXT1_LO];
  end

  // A request is taken only with both enables set
  assign set_vec = irq_src & pin_ok & en_vec & {NSRC{global_irq_enable}};
  // Acknowledge clears only the vector shown in that cycle, never a late winner
  assign ack_vec = irq_ack ? (NSRC'(1) << vec_r) : '0;
  assign pend_nxt = (pend_r & ~ack_vec) | set_vec;

  // Pending latches; a new request in the acknowledge cycle survives
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // Candidates are re-gated so clearing a source or global enable stops service at once; the pin enables are not re-gated
  assign cand = pend_r & en_vec & {NSRC{global_irq_enable}};

  // Split candidates by level
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      cand_lv[l] = '0;
    end
    for (int i = 0; i < NSRC; i++) begin
      cand_lv[lvl_of[i]][i] = cand[i];
    end
  end

  // Highest level wins; inside it the lowest vector wins
  always_comb begin
    if (cand_lv[LVL_TOP] != '0) best_lvl = LVL_TOP;
    else if (cand_lv[LVL_HIGH] != '0) best_lvl = LVL_HIGH;
    else if (cand_lv[LVL_LOW] != '0) best_lvl = LVL_LOW;
    else best_lvl = LVL_NONE;
    poll_vec = pic_first_one(cand_lv[best_lvl]);
  end

  assign cur_top = pic_top_level(active_r);
  // Pre-empt only strictly above the running level; none while shut down
  assign req_nxt = (best_lvl > cur_top) && !core_shutdown_state && !irq_ack;

  // Request and vector registered toward the core
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      req_r <= 1'b0;
      vec_r <= VEC_PSM;
      lvl_r <= LVL_NONE;
    end else begin
      req_r <= req_nxt;
      vec_r <= poll_vec;
      lvl_r <= best_lvl;
    end
  end

  // Nesting stack of levels in service; return pops the highest
  always_comb begin
    active_nxt = active_r;
    if (irq_ret) begin
      case (cur_top)
        LVL_TOP:  active_nxt[2] = 1'b0;
        LVL_HIGH: active_nxt[1] = 1'b0;
        LVL_LOW:  active_nxt[0] = 1'b0;
        default:  active_nxt = active_r;
      endcase
    end
    if (irq_ack && req_r && lvl_r != LVL_NONE) begin
      active_nxt[lvl_r - 2'h1] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_r <= '0;
    end else begin
      active_r <= active_nxt;
    end
  end

  // Wake-up is its own path and never touches pending state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= core_shutdown_state && (wake_src != '0);
    end
  end

  // Event status, write one to clear; the set wins over the clear
  always_comb begin
    clr_vec = '0;
    if (reg_wr && reg_addr == OFS_STAT_LO) clr_vec[7:0] = reg_wdata;
    if (reg_wr && reg_addr == OFS_STAT_HI) clr_vec[NSRC-1:8] = reg_wdata[NSRC-9:0];
    stat_nxt = (stat_r & ~clr_vec) | set_vec;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_r <= '0;
      mask_r <= '0;
    end else begin
      stat_r <= stat_nxt;
      if (reg_wr && reg_addr == OFS_MASK_LO) mask_r[7:0] <= reg_wdata;
      if (reg_wr && reg_addr == OFS_MASK_HI) mask_r[NSRC-1:8] <= reg_wdata[NSRC-9:0];
    end
  end

  // Byte read mux; unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      OFS_IE:      rdata_nxt = irq_enable_main_r;
      OFS_IRQ_ENABLE_PRIORITY_SECOND:   rdata_nxt = irq_enable_priority_second_r;
      OFS_IP:      rdata_nxt = irq_level_main_r;
      OFS_IRQ_PIN_CONFIG:   rdata_nxt = irq_pin_config_r;
      OFS_STAT_LO: rdata_nxt = stat_r[7:0];
      OFS_STAT_HI: rdata_nxt = {4'h0, stat_r[NSRC-1:8]};
      OFS_MASK_LO: rdata_nxt = mask_r[7:0];
      OFS_MASK_HI: rdata_nxt = {4'h0, mask_r[NSRC-1:8]};
      OFS_ACTIVE:  rdata_nxt = {req_r, active_r, vec_r};
      default:     rdata_nxt = 8'h00;
    endcase
    if (!reg_rd) rdata_nxt = 8'h00;
  end

  // Bit read mux; only the two bit-addressable groups answer
  always_comb begin
    brdata_nxt = 1'b0;
    if (bit_rd && pic_bit_hit(bit_addr, BIT_IE_BASE)) brdata_nxt = irq_enable_main_r[bit_addr[2:0]];
    if (bit_rd && pic_bit_hit(bit_addr, BIT_IP_BASE)) brdata_nxt = irq_level_main_r[bit_addr[2:0]];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r  <= 8'h00;
      brdata_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      brdata_r <= brdata_nxt;
    end
  end

  assign reg_rdata  = rdata_r;
  assign bit_rdata  = brdata_r;
  assign irq_req    = req_r;
  assign irq_vector = vec_r;
  assign irq_level  = lvl_r;
  assign core_wake  = wake_r;
  assign sys_irq    = (stat_r & mask_r) != '0;

  // Checks on the arbitration and the register side
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence low_in_service_s;
    active_r == 3'b001 && !irq_ack && !irq_ret && !core_shutdown_state;
  endsequence
  sequence high_waiting_s;
    cand_lv[LVL_HIGH] != '0;
  endsequence
  sequence raised_high_s;
    req_r && lvl_r >= LVL_HIGH;
  endsequence

  pend_latch_a: assert property (set_vec != '0 |=> (pend_r & $past(set_vec)) == $past(set_vec))
    else $error("Enabled request not latched");
  ack_clears_a: assert property (irq_ack && !set_vec[vec_r] |=> !pend_r[$past(vec_r)])
    else $error("Acknowledged request still pending");
  global_gate_a: assert property (!global_irq_enable |=> !req_r)
    else $error("Request raised with global enable clear");
  top_only_psm_a: assert property (req_r && lvl_r == LVL_TOP |-> vec_r == VEC_PSM)
    else $error("Top level held by non-monitor source");
  high_preempts_a: assert property (low_in_service_s ##0 high_waiting_s |=> raised_high_s)
    else $error("High request failed to pre-empt low routine");
  higher_first_a: assert property (req_r |-> $past(cand_lv[LVL_TOP]) == '0 || lvl_r == LVL_TOP)
    else $error("Lower level vectored before top level");
  same_level_block_a: assert property (req_r |-> lvl_r > $past(cur_top))
    else $error("Request does not exceed running level");
  poll_order_a: assert property (req_r |->
      ($past(cand_lv[best_lvl]) & ((NSRC'(1) << vec_r) - NSRC'(1))) == '0)
    else $error("Polling order violated");
  run_only_a: assert property (core_shutdown_state |=> !req_r ##1 !core_shutdown_state [*1]
      or !req_r)
    else $error("Interrupt raised while core shut down");
  wake_path_a: assert property (core_shutdown_state && wake_src != '0 |=> core_wake)
    else $error("Wake event not forwarded");
  bit_write_a: assert property (bw_ie && !wr_ie |=>
      irq_enable_main_r[$past(bit_addr[2:0])] == $past(bit_wdata))
    else $error("Bit write to main enable lost");

  // Top-level path: the monitor must break into a high routine at once
  sequence high_in_service_s;
    active_r[2:1] == 2'b01 && !irq_ack && !irq_ret && !core_shutdown_state;
  endsequence
  sequence top_waiting_s;
    cand_lv[LVL_TOP] != '0;
  endsequence
  sequence raised_top_s;
    req_r && lvl_r == LVL_TOP && vec_r == VEC_PSM;
  endsequence

  top_preempts_a: assert property (high_in_service_s ##0 top_waiting_s |=>
      raised_top_s)
    else $error("Monitor request failed to pre-empt high routine");
  ack_drops_req_a: assert property (irq_ack |=> !req_r)
    else $error("Request still raised after acknowledge");
  stat_set_wins_a: assert property (set_vec != '0 |=>
      (stat_r & $past(set_vec)) == $past(set_vec))
    else $error("Event status lost against a clear");
  read_idle_zero_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("Byte read data outside its cycle");
  bit_idle_zero_a: assert property (!bit_rd |=> !bit_rdata)
    else $error("Bit read data outside its cycle");
  byte_only_a: assert property (bit_wr && !reg_wr |=>
      $stable(irq_enable_priority_second_r))
    else $error("Bit write reached a byte-only register");
  wake_idle_a: assert property (!core_shutdown_state |=> !core_wake)
    else $error("Wake raised while core running");
  no_self_nest_a: assert property (active_r[2] |=> !req_r)
    else $error("Request raised over a running monitor routine");

endmodule : pic_ctrl
`default_nettype wire

// file: hdl/pic_pkg.sv
// Package of constants and helpers for the priority interrupt controller
// Summary of operation
// - Twelve sources arbitrated over three levels
// - Supply monitor alone on top, pre-empts all
// - High request may pre-empt low routine
// - Simultaneous requests: higher level vectored first
// - Same-level request waits until routine returns
// - Equal-level ties resolved by fixed polling
// - Global enable bit 7 gates every source
// - Main enable bits 6..0 enable seven sources
// - Main level register selects high/low per source
// - Only two registers assign lower levels
// - Reset values zero, secondary register a0
// - Bit access for main enable/level registers
// - Wake-up separate; interrupts only while running
// - Secondary bits 3..0 enable four sources
// - Secondary bits 6, 4 set two priorities
package pic_pkg;
  localparam int         NSRC   = 12;
  localparam int         WAKE_W = 4;
  // Byte register offsets
  localparam logic [7:0] OFS_IE      = 8'ha8;
  localparam logic [7:0] OFS_IRQ_ENABLE_PRIORITY_SECOND   = 8'ha9;
  localparam logic [7:0] OFS_IP      = 8'hb8;
  localparam logic [7:0] OFS_IRQ_PIN_CONFIG   = 8'hff;
  localparam logic [7:0] OFS_STAT_LO = 8'he0;
  localparam logic [7:0] OFS_STAT_HI = 8'he1;
  localparam logic [7:0] OFS_MASK_LO = 8'he2;
  localparam logic [7:0] OFS_MASK_HI = 8'he3;
  localparam logic [7:0] OFS_ACTIVE  = 8'he4;
  // Reset values
  localparam logic [7:0] RST_IE    = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE_PRIORITY_SECOND = 8'ha0;
  localparam logic [7:0] RST_IP    = 8'h00;
  localparam logic [7:0] RST_IRQ_PIN_CONFIG = 8'h00;
  localparam logic [7:0] IRQ_PIN_CONFIG_RD_MASK = 8'hef;
  // Bit address bases of the bit-addressable registers
  localparam logic [7:0] BIT_IE_BASE = 8'ha8;
  localparam logic [7:0] BIT_IP_BASE = 8'hb8;
  // Main enable / level bit positions
  localparam int IE_GLOBAL = 7;
  localparam int B_TEMP = 6, B_T2 = 5, B_UART = 4, B_T1 = 3, B_EXT1 = 2, B_T0 = 1, B_EXT0 = 0;
  localparam int B_ENERGY_PRI = 7;
  // Secondary enable-and-priority bit positions
  localparam int E2_RTC_PRI = 6, E2_SBUS_PRI = 4, E2_ENERGY_EN = 3;
  localparam int E2_RTC_EN = 2, E2_PSM_EN = 1, E2_SBUS_EN = 0;
  // Pin configuration bit positions
  localparam int PIN_EXT0_EN = 0, PIN_EXT1_HI = 3, PIN_EXT1_LO = 2;
  // Vector numbers, also the polling order
  localparam logic [3:0] VEC_PSM = 4'h0, VEC_EXT0 = 4'h1, VEC_T0 = 4'h2, VEC_EXT1 = 4'h3;
  localparam logic [3:0] VEC_T1 = 4'h4, VEC_UART = 4'h5, VEC_T2 = 4'h6, VEC_TEMP = 4'h7;
  localparam logic [3:0] VEC_ENERGY = 4'h8, VEC_RTC = 4'h9, VEC_SBUS = 4'ha, VEC_AUX = 4'hb;
  // Levels
  localparam logic [1:0] LVL_NONE = 2'h0, LVL_LOW = 2'h1, LVL_HIGH = 2'h2, LVL_TOP = 2'h3;

  // Highest level whose routine is in service
  function automatic logic [1:0] pic_top_level(input logic [2:0] act);
    if (act[2]) return LVL_TOP;
    else if (act[1]) return LVL_HIGH;
    else if (act[0]) return LVL_LOW;
    else return LVL_NONE;
  endfunction : pic_top_level

  // Index of the lowest set bit
  function automatic logic [3:0] pic_first_one(input logic [NSRC-1:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) idx = i[3:0];
    end
    return idx;
  endfunction : pic_first_one

  // Bit address falls inside an eight-bit group
  function automatic logic pic_bit_hit(input logic [7:0] a, input logic [7:0] base);
    return a[7:3] == base[7:3];
  endfunction : pic_bit_hit
endpackage : pic_pkg

// file: test/pic_core_model.sv
// Core-side partner: takes vector requests and returns from routines
`timescale 1ns/1ns
`default_nettype none
module pic_core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Timing knobs set by the bench
  input  wire logic [7:0] ack_dly,
  input  wire logic [7:0] svc_len,
  // Core handshake
  input  wire logic       irq_req,
  output logic            irq_ack,
  output logic            irq_ret
);
  logic [7:0] wait_r;
  logic [7:0] svc_r;
  logic [3:0] depth_r;

  // Take a request after a set wait; ack high blocks a second take in the next cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_ack <= 1'b0;
      wait_r  <= 8'h00;
    end else if (irq_req && !irq_ack && wait_r >= ack_dly) begin
      irq_ack <= 1'b1;
      wait_r  <= 8'h00;
    end else if (irq_req && !irq_ack) begin
      wait_r <= wait_r + 8'h01;
    end else begin
      irq_ack <= 1'b0;
      wait_r  <= 8'h00;
    end
  end

  // Innermost routine returns svc_len cycles after the last take or return
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_ret <= 1'b0;
      svc_r   <= 8'h00;
      depth_r <= 4'h0;
    end else if (irq_ack) begin
      irq_ret <= 1'b0;
      svc_r   <= 8'h00;
      depth_r <= depth_r + 4'h1;
    end else if (depth_r != 4'h0 && !irq_ret && svc_r >= svc_len) begin
      irq_ret <= 1'b1;
      svc_r   <= 8'h00;
      depth_r <= depth_r - 4'h1;
    end else begin
      irq_ret <= 1'b0;
      svc_r   <= svc_r + 8'h01;
    end
  end
endmodule : pic_core_model
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the priority interrupt controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pic_pkg::*;
  logic        clk, rstn, reg_wr, reg_rd, bit_wdata, bit_wr, bit_rd;
  logic        shut, ack, ret, irq_req, core_wake, sys_irq, bit_rdata, rd_d, brd_d;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, bit_addr, ack_dly, svc_len, ipr, sec;
  logic [11:0] irq_src, m;
  logic [3:0]  irq_vector, wake_src;
  logic [1:0]  irq_level;
  logic [31:0] rng;
  logic [7:0]  rq[$];
  logic [5:0]  vq[$];
  int          error_cnt, num_checks, cyc;

  pic_ctrl u_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_addr(bit_addr),
    .bit_wdata(bit_wdata), .bit_wr(bit_wr), .bit_rd(bit_rd), .bit_rdata(bit_rdata),
    .irq_src(irq_src), .core_shutdown_state(shut), .irq_ack(ack), .irq_ret(ret),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
    .wake_src(wake_src), .core_wake(core_wake), .sys_irq(sys_irq));
  pic_core_model u_core (.clk(clk), .rstn(rstn), .ack_dly(ack_dly), .svc_len(svc_len),
    .irq_req(irq_req), .irq_ack(ack), .irq_ret(ret));

  task automatic give_verdict();
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Empty queue yields unknown, so a surplus result always mismatches
  function automatic logic [7:0] pop_rd();
    if (rq.size() == 0) return 8'hxx;
    return rq.pop_front();
  endfunction : pop_rd

  function automatic logic [5:0] pop_v();
    if (vq.size() == 0) return 6'hxx;
    return vq.pop_front();
  endfunction : pop_v

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // Expected level of a vector under given main and secondary settings
  function automatic logic [1:0] lv(input int v, input logic [7:0] p, input logic [7:0] s);
    if (v == 0) return LVL_TOP;
    if (v <= 8) return p[v-1] ? LVL_HIGH : LVL_LOW;
    if (v == 9) return s[6] ? LVL_HIGH : LVL_LOW;
    if (v == 10) return s[4] ? LVL_HIGH : LVL_LOW;
    return LVL_LOW;
  endfunction : lv

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic bacc(input logic [7:0] a, input logic d, input logic w);
    @(posedge clk);
    bit_addr  <= a;
    bit_wdata <= d;
    bit_wr    <= w;
    bit_rd    <= !w;
    if (!w) rq.push_back({7'h00, d});
    @(posedge clk);
    bit_wr <= 1'b0;
    bit_rd <= 1'b0;
  endtask : bacc

  task automatic pulse(input logic [11:0] v);
    @(posedge clk);
    irq_src <= v;
    @(posedge clk);
    irq_src <= 12'h000;
  endtask : pulse

  // Look at a settled output just after the nth edge; sampled then, not at the call
  task automatic look(input string nm, input logic e, input int n);
    repeat (n) @(posedge clk);
    #1;
    chk(nm, {7'h00, (nm == "sys_irq") ? sys_irq : irq_req}, {7'h00, e});
  endtask : look

  task automatic drain();
    int i;
    for (i = 0; i < 3000 && vq.size() != 0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask : drain

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Result watcher: read data the cycle after a read, vector at each take
  always @(posedge clk) begin
    rd_d  <= reg_rd;
    brd_d <= bit_rd;
  end
  always @(negedge clk) begin
    if (rd_d) chk("reg_rdata", reg_rdata, pop_rd());
    if (brd_d) chk("bit_rdata", {7'h00, bit_rdata}, pop_rd());
    if (ack) chk("level_vector", {2'b00, irq_level, irq_vector}, {2'b00, pop_v()});
  end

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    {rstn, reg_wr, reg_rd, bit_wdata, bit_wr, bit_rd, shut} = '0;
    {reg_addr, reg_wdata, bit_addr, irq_src, wake_src} = '0;
    {error_cnt, num_checks, cyc} = '0;
    ack_dly = 8'h01;
    svc_len = 8'h03;
    rng = 32'hc88e;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(8'ha8, 8'h00);
    rd(8'ha9, 8'ha0);
    rd(8'hb8, 8'h00);
    rd(8'hff, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'hff, 8'hff);
    rd(8'hff, 8'hef);
    wr(8'hff, 8'h0d);
    // One low request, then its sticky status and the system line
    wr(8'ha8, 8'h90);
    vq.push_back({LVL_LOW, 4'h5});
    pulse(12'h020);
    drain();
    rd(8'he0, 8'h20);
    look("sys_irq", 1'b0, 1);
    wr(8'he2, 8'h20);
    look("sys_irq", 1'b1, 1);
    wr(8'he0, 8'h20);
    look("sys_irq", 1'b0, 1);
    wr(8'he2, 8'h00);
    // Global enable off: nothing latched, nothing served later
    wr(8'ha8, 8'h10);
    pulse(12'h020);
    look("irq_req", 1'b0, 4);
    bacc(8'haf, 1'b1, 1'b1);
    bacc(8'haf, 1'b1, 1'b0);
    look("irq_req", 1'b0, 4);
    // Shut-down core: wake only; the held request is served on resume
    @(posedge clk) shut <= 1'b1;
    vq.push_back({LVL_LOW, 4'h5});
    pulse(12'h020);
    look("irq_req", 1'b0, 4);
    @(posedge clk) wake_src <= 4'h1;
    @(posedge clk) wake_src <= 4'h0;
    #1 chk("core_wake", {7'h00, core_wake}, 8'h01);
    @(posedge clk) shut <= 1'b0;
    drain();
    // Nesting: low, same low blocked, high pre-empts, then the top level
    wr(8'ha8, 8'h9a);
    bacc(8'hbb, 1'b1, 1'b1);
    wr(8'ha9, 8'ha2);
    svc_len <= 8'd40;
    vq = '{{LVL_LOW, 4'h2}, {LVL_HIGH, 4'h4}, {LVL_TOP, 4'h0}, {LVL_LOW, 4'h5}};
    pulse(12'h004);
    repeat (8) @(posedge clk);
    pulse(12'h020);
    look("irq_req", 1'b0, 4);
    pulse(12'h010);
    repeat (8) @(posedge clk);
    pulse(12'h001);
    drain();
    // Random levels and simultaneous sets; first round raises all twelve
    wr(8'ha8, 8'hff);
    svc_len <= 8'h02;
    for (int r = 0; r < 6; r++) begin
      rng = xs(rng);
      ipr = rng[7:0];
      sec = 8'haf | (rng[15:8] & 8'h50);
      m = (r == 0) ? 12'hfff : rng[27:16];
      ack_dly <= {6'h00, rng[29:28]};
      wr(8'hb8, ipr);
      wr(8'ha9, sec);
      rd(8'hb8, ipr);
      rd(8'ha9, sec);
      for (int l = 3; l >= 1; l--) begin
        for (int v = 0; v < 12; v++) begin
          if (m[v] && lv(v, ipr, sec) == l[1:0]) vq.push_back({l[1:0], v[3:0]});
        end
      end
      pulse(m);
      drain();
      if (r == 0) rd(8'he1, 8'h0f);
    end
    chk("notes_left", 8'(vq.size()), 8'h00);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
